// ==== hdl/uwbpm_regs.vh ====
`ifndef UWBPM_REGS_VH
`define UWBPM_REGS_VH

// register indices on the plain register port
`define UWBPM_ADDR_CTRL     4'h0
`define UWBPM_ADDR_WADDR    4'h1
`define UWBPM_ADDR_WDATA    4'h2
`define UWBPM_ADDR_STATUS   4'h3
`define UWBPM_ADDR_PERIOD   4'h4

// control register fields
`define UWBPM_CTRL_W        9
`define UWBPM_CTRL_MODE     0
`define UWBPM_CTRL_JUMPER   2
`define UWBPM_CTRL_GROUP1   3
`define UWBPM_CTRL_FIRST_SHAPE_SELECT     4
`define UWBPM_CTRL_GROUP2   6
`define UWBPM_CTRL_SECOND_SHAPE_SELECT     7
`define UWBPM_CTRL_RST      9'h000

// mode switch codes
`define UWBPM_MODE_POS      2'h0
`define UWBPM_MODE_BIPH     2'h1
`define UWBPM_MODE_ORTH     2'h2

// timing, in ns
`define UWBPM_CLK_NS        40
`define UWBPM_PULSE_NS      60000
`define UWBPM_SHIFT_NS      35000
`define UWBPM_SAMPLE_NS     1000

`endif

// ==== hdl/uwbpm_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "uwbpm_regs.vh"

// What this block does
// R1: source changes data bits on clock rising edge
// R2: both channels timed from one shared clock
// R3: pulses start at the clock falling edge
// R4: each pulse lasts 60 us
// R5: position mode delays pulse 35 us on high
// R6: bi-phase mode inverts pulse on low bit
// R7: keying mode: pulse on high, nothing on low
// R8: keying jumper acts only in bi-phase mode
// R9: orthogonal: channel two shape follows its bit
// R10: orthogonal: channel one always first-select reference
// R11: shape picked by group and two select bits
// R12: delay path outputs input half a bit later
// R13: source clock stays below 10 kHz
// R14: memory addressed by shape and sample counter
// R15: bit sampled at rising edge, held for pulse

module uwbpm_top
(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_b_i,
	// register port
	input  wire [3:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output wire [31:0] reg_rdata_o,
	// data source
	input  wire        bit_clk_i,
	input  wire        data1_i,
	input  wire        data2_i,
	// half-bit delay path
	input  wire        delay_in_i,
	output wire        delay_out_o,
	// shaped pulse outputs
	output wire [7:0]  out1_o,
	output wire [7:0]  out2_o,
	output wire [1:0]  pulse_busy_o
);

	localparam integer SAMPLE_CYC    = `UWBPM_SAMPLE_NS / `UWBPM_CLK_NS;
	localparam integer PULSE_SAMPLES = `UWBPM_PULSE_NS / `UWBPM_SAMPLE_NS;
	localparam integer SHIFT_CYC     = (`UWBPM_SHIFT_NS + `UWBPM_CLK_NS - 1) / `UWBPM_CLK_NS;
	localparam [4:0] PRE_LAST   = SAMPLE_CYC[4:0] - 5'h01;
	localparam [5:0] IDX_LAST   = PULSE_SAMPLES[5:0] - 6'h01;
	localparam [9:0] SHIFT_LAST = SHIFT_CYC[9:0] - 10'h001;

	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_SHIFT = 2'h1;
	localparam [1:0] ST_RUN   = 2'h2;

	integer c;

	// register side
	reg  [`UWBPM_CTRL_W-1:0] ctrl_r;
	reg  [8:0]               wptr_r;
	reg  [31:0]              rdata_r;
	wire                     mem_we_w;

	// source clock edges and data
	reg                      bclk_prev_r;
	wire                     rise_w;
	wire                     fall_w;
	wire [1:0]               data_w;
	reg  [1:0]               bit_r;

	// per channel pulse engine
	reg  [1:0]               st_r     [0:1];
	reg  [4:0]               pre_r    [0:1];
	reg  [5:0]               idx_r    [0:1];
	reg  [9:0]               wait_r   [0:1];
	reg  [2:0]               shape_r  [0:1];
	reg  [1:0]               inv_r;
	reg  [1:0]               run_d_r;
	reg  [1:0]               act_r;
	reg  [7:0]               out_r    [0:1];
	wire [7:0]               rd0_w;
	wire [7:0]               rd1_w;

	// half-bit delay path
	reg  [19:0]              per_cnt_r;
	reg  [19:0]              period_r;
	reg                      period_ok_r;
	reg  [19:0]              dly_cnt_r;
	reg                      dly_cap_r;
	reg                      dly_pend_r;
	reg                      delay_out_r;

	// decoded control fields
	wire [1:0]               mode_w;
	wire                     jumper_w;
	wire                     keying_w;

	// negation saturates so the most negative code stays in range
	function [7:0] neg_sat;
		input [7:0] s;
		begin
			neg_sat = (s == 8'h80) ? 8'h7f : (~s + 8'h01);
		end
	endfunction

	// shape index for a channel given its bit and the mode
	function [2:0] shape_of;
		input                    chan;
		input                    bit_v;
		input [1:0]              mode;
		input [`UWBPM_CTRL_W-1:0] ctrl;
		reg                      use_first;
		begin
			use_first = (chan == 1'b0) || ((mode == `UWBPM_MODE_ORTH) && bit_v); // R9 R10
			if (use_first)
			begin
				shape_of = {ctrl[`UWBPM_CTRL_GROUP1], ctrl[`UWBPM_CTRL_FIRST_SHAPE_SELECT +: 2]}; // R11
			end
			else
			begin
				shape_of = {ctrl[`UWBPM_CTRL_GROUP2], ctrl[`UWBPM_CTRL_SECOND_SHAPE_SELECT +: 2]}; // R11
			end
		end
	endfunction

	assign mode_w   = ctrl_r[`UWBPM_CTRL_MODE +: 2];
	assign jumper_w = ctrl_r[`UWBPM_CTRL_JUMPER];
	assign keying_w = (mode_w == `UWBPM_MODE_BIPH) && jumper_w; // R8

	assign data_w   = {data2_i, data1_i};
	// one shared source clock times both channels
	assign rise_w   = bit_clk_i & ~bclk_prev_r; // R2
	assign fall_w   = ~bit_clk_i & bclk_prev_r; // R2 R3
	assign mem_we_w = reg_wr_i && (reg_addr_i == `UWBPM_ADDR_WDATA);

	// register port: writes take effect at once, reads answer a cycle later
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctrl_r  <= `UWBPM_CTRL_RST;
			wptr_r  <= 9'h000;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			rdata_r <= 32'h0000_0000;
			if (reg_wr_i && (reg_addr_i == `UWBPM_ADDR_CTRL))
			begin
				ctrl_r <= reg_wdata_i[`UWBPM_CTRL_W-1:0];
			end
			if (reg_wr_i && (reg_addr_i == `UWBPM_ADDR_WADDR))
			begin
				wptr_r <= reg_wdata_i[8:0];
			end
			else if (mem_we_w)
			begin
				// auto increment lets a whole shape load as a burst
				wptr_r <= wptr_r + 9'h001;
			end
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					`UWBPM_ADDR_CTRL:
						rdata_r <= {23'h00_0000, ctrl_r};
					`UWBPM_ADDR_WADDR:
						rdata_r <= {23'h00_0000, wptr_r};
					`UWBPM_ADDR_STATUS:
						rdata_r <= {26'h000_0000, period_ok_r, delay_out_r, bit_r, act_r};
					`UWBPM_ADDR_PERIOD:
						rdata_r <= {12'h000, period_r};
					default:
						rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// source clock edge tracking and bit sampling
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bclk_prev_r <= 1'b0;
			bit_r       <= 2'h0;
		end
		else
		begin
			bclk_prev_r <= bit_clk_i;
			if (rise_w)
			begin
				// source moves data with the rising edge, so it is fresh here
				bit_r <= data_w; // R1 R15
			end
		end
	end

	// pulse engines, one per channel
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (c = 0; c < 2; c = c + 1)
			begin
				st_r[c]    <= ST_IDLE;
				pre_r[c]   <= 5'h00;
				idx_r[c]   <= 6'h00;
				wait_r[c]  <= 10'h000;
				shape_r[c] <= 3'h0;
				out_r[c]   <= 8'h00;
			end
			inv_r   <= 2'h0;
			run_d_r <= 2'h0;
			act_r   <= 2'h0;
		end
		else
		begin
			for (c = 0; c < 2; c = c + 1)
			begin
				// memory read adds one cycle, so run state is delayed to match
				run_d_r[c] <= (st_r[c] == ST_RUN);
				act_r[c]   <= run_d_r[c];
				if (!run_d_r[c])
				begin
					out_r[c] <= 8'h00; // R7
				end
				else if (inv_r[c])
				begin
					out_r[c] <= neg_sat((c == 0) ? rd0_w : rd1_w); // R6
				end
				else
				begin
					out_r[c] <= (c == 0) ? rd0_w : rd1_w;
				end

				if (fall_w)
				begin
					// a new edge restarts a pulse still running
					shape_r[c] <= shape_of(c[0], bit_r[c], mode_w, ctrl_r); // R9 R10 R11 R15
					inv_r[c]   <= (mode_w == `UWBPM_MODE_BIPH) && !jumper_w && !bit_r[c]; // R6 R8
					pre_r[c]   <= 5'h00; // R14
					idx_r[c]   <= 6'h00; // R14
					wait_r[c]  <= 10'h000;
					if ((mode_w == 2'h3) || (keying_w && !bit_r[c]))
					begin
						st_r[c] <= ST_IDLE; // R7
					end
					else if ((mode_w == `UWBPM_MODE_POS) && bit_r[c])
					begin
						st_r[c] <= ST_SHIFT; // R5
					end
					else
					begin
						st_r[c] <= ST_RUN; // R3
					end
				end
				else
				begin
					case (st_r[c])
						ST_SHIFT:
						begin
							if (wait_r[c] == SHIFT_LAST)
							begin
								st_r[c] <= ST_RUN; // R5
							end
							else
							begin
								wait_r[c] <= wait_r[c] + 10'h001;
							end
						end
						ST_RUN:
						begin
							if (pre_r[c] == PRE_LAST)
							begin
								pre_r[c] <= 5'h00;
								if (idx_r[c] == IDX_LAST)
								begin
									st_r[c] <= ST_IDLE; // R4 R14
								end
								else
								begin
									idx_r[c] <= idx_r[c] + 6'h01; // R14
								end
							end
							else
							begin
								pre_r[c] <= pre_r[c] + 5'h01; // R4
							end
						end
						default:
						begin
							st_r[c] <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// half-bit delay: period measured between rising edges
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			per_cnt_r   <= 20'h0_0000;
			period_r    <= 20'h0_0000;
			period_ok_r <= 1'b0;
			dly_cnt_r   <= 20'h0_0000;
			dly_cap_r   <= 1'b0;
			dly_pend_r  <= 1'b0;
			delay_out_r <= 1'b0;
		end
		else
		begin
			if (rise_w)
			begin
				// counter width covers the slowest source clock
				per_cnt_r   <= 20'h0_0000; // R13
				period_r    <= (&per_cnt_r) ? per_cnt_r : per_cnt_r + 20'h0_0001;
				period_ok_r <= (per_cnt_r != 20'hf_ffff);
				dly_cap_r   <= delay_in_i;
				// uses the previous bit's length; first bit passes at once
				dly_cnt_r   <= {1'b0, period_r[19:1]}; // R12
				dly_pend_r  <= 1'b1;
			end
			else
			begin
				if (per_cnt_r != 20'hf_ffff)
				begin
					per_cnt_r <= per_cnt_r + 20'h0_0001;
				end
				if (dly_pend_r)
				begin
					if (dly_cnt_r == 20'h0_0000)
					begin
						delay_out_r <= dly_cap_r; // R12
						dly_pend_r  <= 1'b0;
					end
					else
					begin
						dly_cnt_r <= dly_cnt_r - 20'h0_0001;
					end
				end
			end
		end
	end

	uwbpm_wave_mem u_wave
	(
		.clk_i    (clk_i),
		.we_i     (mem_we_w),
		.waddr_i  (wptr_r),
		.wdata_i  (reg_wdata_i[7:0]),
		.raddr0_i ({shape_r[0], idx_r[0]}), // R14
		.raddr1_i ({shape_r[1], idx_r[1]}), // R14
		.rdata0_o (rd0_w),
		.rdata1_o (rd1_w)
	);

	assign reg_rdata_o  = rdata_r;
	assign delay_out_o  = delay_out_r;
	assign out1_o       = out_r[0];
	assign out2_o       = out_r[1];
	assign pulse_busy_o = act_r;

endmodule // uwbpm_top

`default_nettype wire

// ==== hdl/uwbpm_wave_mem.v ====
`timescale 1ns/100ps
`default_nettype none

module uwbpm_wave_mem
(
	// clock
	input  wire       clk_i,
	// write port from the register side
	input  wire       we_i,
	input  wire [8:0] waddr_i,
	input  wire [7:0] wdata_i,
	// one read port per channel
	input  wire [8:0] raddr0_i,
	input  wire [8:0] raddr1_i,
	output reg  [7:0] rdata0_o,
	output reg  [7:0] rdata1_o
);

	// eight shapes of 64 samples; no reset, software loads it
	reg [7:0] mem_r [0:511];

	always @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem_r[waddr_i] <= wdata_i;
		end
		rdata0_o <= mem_r[raddr0_i];
		rdata1_o <= mem_r[raddr1_i];
	end

endmodule // uwbpm_wave_mem

`default_nettype wire

// ==== test/tb_ultra_wideband_pulse_modulator.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "uwbpm_regs.vh"

module tb_ultra_wideband_pulse_modulator;
	logic        clk_i;
	logic        rst_b_i;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	wire  [31:0] reg_rdata_o;
	wire         bit_clk_i;
	wire         data1_i;
	wire         data2_i;
	wire         delay_in_i;
	wire         delay_out_o;
	wire  [7:0]  out1_o;
	wire  [7:0]  out2_o;
	wire  [1:0]  pulse_busy_o;
	logic        src_en;
	logic        nb1;
	logic        nb2;
	logic        dprev;
	logic [31:0] v;
	int          n_mismatch;
	int          comparisons;
	int          i;

	uwbpm_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .bit_clk_i(bit_clk_i), .data1_i(data1_i),
		.data2_i(data2_i), .delay_in_i(delay_in_i), .delay_out_o(delay_out_o),
		.out1_o(out1_o), .out2_o(out2_o), .pulse_busy_o(pulse_busy_o));
	uwbpm_src_model u_src (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(src_en),
		.nxt1_i(nb1), .nxt2_i(nb2), .bit_clk_o(bit_clk_i), .data1_o(data1_i),
		.data2_o(data2_i), .delay_in_o(delay_in_i));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	// shapes are {group, select}
	function automatic logic [8:0] mk(input logic [1:0] m, input logic j,
		input logic [2:0] s1, input logic [2:0] s2);
		return {s2[1:0], s2[2], s1[1:0], s1[2], j, m};
	endfunction

	// {delayed, first sample}
	function automatic logic [8:0] exp_of(input logic [8:0] c, input logic b,
		input logic [2:0] sh);
		logic [7:0] s;
		s = {1'b0, sh, 4'h1};
		case (c[1:0])
			`UWBPM_MODE_POS:  return {b, s};
			`UWBPM_MODE_BIPH: return {1'b0, b ? s : (c[2] ? 8'h00 : 8'h00 - s)};
			`UWBPM_MODE_ORTH: return {1'b0, s};
			default:          return 9'h000;
		endcase
	endfunction

	task automatic run_bit(input logic [8:0] c, input logic d1, input logic d2);
		logic [8:0] e1;
		logic [8:0] e2;
		logic       p;
		int         k;
		e1 = exp_of(c, d1, {c[3], c[5:4]});
		e2 = exp_of(c, d2, (c[1:0] == `UWBPM_MODE_ORTH && d2) ? {c[3], c[5:4]} : {c[6], c[8:7]});
		reg_write(`UWBPM_ADDR_CTRL, {23'h00_0000, c});
		reg_read(`UWBPM_ADDR_CTRL, v);
		chk(v, {23'h00_0000, c});
		nb1 <= d1;
		nb2 <= d2;
		src_en <= 1'b1;
		k = 0;
		p = 1'b0;
		while (!(p && !bit_clk_i) && k < 4000)
		begin
			p = bit_clk_i;
			tick(1);
			k++;
		end
		if (k >= 4000)
		begin
			n_mismatch++;
			print_verdict();
		end
		chk(delay_out_o, dprev);
		dprev = d1 ^ d2;
		tick(1);
		chk(pulse_busy_o, 2'b00);
		// fall seen one edge late, memory read adds one more
		tick(2);
		chk(out1_o, e1[8] ? 8'h00 : e1[7:0]);
		chk(out2_o, e2[8] ? 8'h00 : e2[7:0]);
		chk(pulse_busy_o, {!e2[8] && e2[7:0] != 0, !e1[8] && e1[7:0] != 0});
		chk(delay_out_o, dprev);
		if (e1[8] || e2[8])
		begin
			tick(874);
			chk(pulse_busy_o, {!e2[8] && e2[7:0] != 0, !e1[8] && e1[7:0] != 0});
			tick(1);
			// an unshifted channel is 35 samples in by now
			chk(out1_o, e1[8] ? e1[7:0] : {e1[7:4], 4'h6});
			chk(out2_o, e2[8] ? e2[7:0] : {e2[7:4], 4'h6});
		end
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial
	begin
		rst_b_i = 1'b1;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0000_0000;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		src_en = 1'b0;
		nb1 = 1'b0;
		nb2 = 1'b0;
		dprev = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		// reset edge after time zero, so every flop sees it
		#5 rst_b_i = 1'b0;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// memory is not reset, so every address gets a value
		reg_write(`UWBPM_ADDR_WADDR, 32'h0000_0000);
		for (i = 0; i < 512; i++)
			reg_write(`UWBPM_ADDR_WDATA, {24'h00_0000, 1'b0, i[8:6], 4'h0} + (i % 64) % 15 + 1);
		reg_read(`UWBPM_ADDR_WDATA, v);
		chk(v, 32'h0000_0000);
		reg_read(4'h5, v);
		chk(v, 32'h0000_0000);
		run_bit(mk(2'h3, 1'b0, 3'h2, 3'h5), 1'b1, 1'b1);
		reg_read(`UWBPM_ADDR_STATUS, v);
		chk(v & 32'h0000_000c, 32'h0000_000c);
		run_bit(mk(2'h0, 1'b0, 3'h0, 3'h7), 1'b1, 1'b1);
		reg_read(`UWBPM_ADDR_PERIOD, v);
		chk(v & 32'h000f_ffff, 32'h0000_0bb8);
		reg_write(4'h5, 32'h0000_01ff);
		reg_read(`UWBPM_ADDR_CTRL, v);
		chk(v, {23'h00_0000, mk(2'h0, 1'b0, 3'h0, 3'h7)});
		run_bit(mk(2'h0, 1'b1, 3'h3, 3'h4), 1'b0, 1'b1);
		run_bit(mk(2'h1, 1'b0, 3'h5, 3'h2), 1'b0, 1'b1);
		run_bit(mk(2'h1, 1'b0, 3'h5, 3'h2), 1'b1, 1'b0);
		run_bit(mk(2'h1, 1'b1, 3'h6, 3'h1), 1'b1, 1'b0);
		run_bit(mk(2'h1, 1'b1, 3'h6, 3'h1), 1'b0, 1'b1);
		run_bit(mk(2'h2, 1'b0, 3'h6, 3'h1), 1'b0, 1'b1);
		run_bit(mk(2'h2, 1'b0, 3'h6, 3'h1), 1'b1, 1'b0);
		for (i = 0; i < 8; i++)
			run_bit(mk(2'h0, 1'b0, i[2:0], ~i[2:0]), 1'b0, 1'b0);
		print_verdict();
	end
endmodule // tb_ultra_wideband_pulse_modulator

`default_nettype wire

// ==== test/uwbpm_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

module uwbpm_checker
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// watched ports
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        bit_clk_i,
	input wire logic [7:0]  out1_o,
	input wire logic [7:0]  out2_o,
	input wire logic [1:0]  pulse_busy_o
);
	logic        bprev_r;
	logic [11:0] sf_r;
	logic [11:0] c1_r;
	logic [11:0] c2_r;

	// cycles since fall saturate, only short windows matter
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bprev_r <= 1'b0;
			sf_r    <= 12'h000;
			c1_r    <= 12'h000;
			c2_r    <= 12'h000;
		end
		else
		begin
			bprev_r <= bit_clk_i;
			sf_r    <= (bprev_r && !bit_clk_i) ? 12'h000 : ((&sf_r) ? sf_r : sf_r + 12'h001);
			c1_r    <= pulse_busy_o[0] ? c1_r + 12'h001 : 12'h000;
			c2_r    <= pulse_busy_o[1] ? c2_r + 12'h001 : 12'h000;
		end
	end

	rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000) else $error("stray read data");
	busy1_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$fell(pulse_busy_o[0]) |-> c1_r == 12'h5dc) else $error("pulse one length");
	busy2_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$fell(pulse_busy_o[1]) |-> c2_r == 12'h5dc) else $error("pulse two length");
	sample_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		pulse_busy_o[0] && c1_r != 12'h000 && $changed(out1_o) |-> c1_r % 25 == 0)
		else $error("sample changed off its slot");
	idle_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(pulse_busy_o[0] || out1_o == 8'h00) && (pulse_busy_o[1] || out2_o == 8'h00))
		else $error("output not zero while idle");
	start_one_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(pulse_busy_o[0]) |-> sf_r == 12'h002 || sf_r == 12'h36d)
		else $error("pulse one start off the falling edge");
	start_two_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(pulse_busy_o[1]) |-> sf_r == 12'h002 || sf_r == 12'h36d)
		else $error("pulse two start off the falling edge");
	reset_quiet_a: assert property (@(posedge clk_i)
		!rst_b_i |-> out1_o == 8'h00 && out2_o == 8'h00 && pulse_busy_o == 2'b00)
		else $error("outputs active in reset");
endmodule // uwbpm_checker

bind uwbpm_top uwbpm_checker u_chk
(
	.clk_i        (clk_i),
	.rst_b_i      (rst_b_i),
	.reg_rd_i     (reg_rd_i),
	.reg_rdata_o  (reg_rdata_o),
	.bit_clk_i    (bit_clk_i),
	.out1_o       (out1_o),
	.out2_o       (out2_o),
	.pulse_busy_o (pulse_busy_o)
);

`default_nettype wire

// ==== test/uwbpm_src_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module uwbpm_src_model
#(
	parameter int HALF = 1500
)
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// bench control
	input  wire logic en_i,
	input  wire logic nxt1_i,
	input  wire logic nxt2_i,
	// lines into the block
	output logic      bit_clk_o,
	output logic      data1_o,
	output logic      data2_o,
	output logic      delay_in_o
);
	int cnt;

	// clock holds its level while disabled and reset leaves it low, so no stray pulses from an empty memory
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt        <= 0;
			bit_clk_o  <= 1'b0;
			data1_o    <= 1'b0;
			data2_o    <= 1'b0;
			delay_in_o <= 1'b0;
		end
		else if (en_i)
		begin
			cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
			if (cnt == 0)
			begin
				bit_clk_o  <= 1'b1;
				data1_o    <= nxt1_i;
				data2_o    <= nxt2_i;
				delay_in_o <= nxt1_i ^ nxt2_i;
			end
			if (cnt == HALF)
				bit_clk_o <= 1'b0;
		end
	end
endmodule // uwbpm_src_model

`default_nettype wire
